/* File: hdl/adc_flag_control.sv */
// Flag and sequencing logic of the 8-bit successive-approximation converter
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module adc_flag_control
   import adc_flag_pkg::*;
(
   input  wire logic              CORE_CLK,
   input  wire logic              RST_N,
   input  wire logic [ADDR_W-1:0] BUS_ADDR,
   input  wire logic [DATA_W-1:0] BUS_WDATA,
   input  wire logic              BUS_WR,
   input  wire logic              BUS_RD,
   output var  logic [DATA_W-1:0] BUS_RDATA,
   input  wire logic              COMP_IN,
   output var  logic [DATA_W-1:0] DAC_CODE,
   output var  logic              IRQ
);
   // ****************************************
   // Bus decode
   // ****************************************
   bus_req_type       req;
   logic              start_wr;
   logic              start_set;
   logic              data_wr;
   logic              flags_wr;
   logic              stat_wr;
   logic              mask_wr;

   assign req       = '{addr: BUS_ADDR, wdata: BUS_WDATA, wr: BUS_WR, rd: BUS_RD};
   assign start_wr  = req.wr && (req.addr == OFS_START);
   assign start_set = start_wr && req.wdata[BIT_START];
   assign data_wr   = req.wr && (req.addr == OFS_DATA);
   assign flags_wr  = req.wr && (req.addr == OFS_FLAGS);
   assign stat_wr   = req.wr && (req.addr == OFS_IRQ_STAT);
   assign mask_wr   = req.wr && (req.addr == OFS_IRQ_MASK);

   // ****************************************
   // State
   // ****************************************
   state_type         state_q;
   logic [1:0]        tick_cnt_q;
   logic [1:0]        instr_q;
   logic [2:0]        bit_idx_q;
   logic [1:0]        settle_q;
   logic              mode_select_q;
   logic              conversion_start_q;
   logic              conversion_done_q;
   logic              compare_result_q;
   logic [DATA_W-1:0] conv_data_q;
   logic [1:0]        irq_stat_q;
   logic [1:0]        irq_mask_q;
   logic              tick;
   logic              bit_end;
   logic              settled;
   logic              done_evt;
   logic              cmp_evt;
   logic [DATA_W-1:0] trial_d;

   assign tick     = (tick_cnt_q == TICK_LAST);
   assign bit_end  = (state_q == ST_CONV) && tick && (instr_q == BIT_LAST);
   assign settled  = (settle_q == SETTLE_DONE);
   assign done_evt = bit_end && (bit_idx_q == 3'h0);
   assign cmp_evt  = (state_q == ST_SINGLE) && tick && (settle_q == 2'(SETTLE_INSTR - 1)) && !data_wr && !start_set;

   // Trial code keeps decided bits and sets the bit under test
   always_comb begin
      trial_d = conv_data_q;
      if (state_q == ST_CONV) begin
         trial_d[bit_idx_q] = 1'b1;
      end
   end

   // Instruction grid restarts on start writes that set the start bit and on data writes so timing is exact
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N || start_set || data_wr) begin
         tick_cnt_q <= 2'h0;
      end else begin
         tick_cnt_q <= tick ? 2'h0 : tick_cnt_q + 2'h1;
      end
   end

   // ****************************************
   // Sequencer
   // ****************************************
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         state_q   <= ST_IDLE;
         instr_q   <= 2'h0;
         bit_idx_q <= 3'h7;
      end else if (start_set) begin
         state_q <= ST_START;
         instr_q <= 2'h0;
      end else begin
         case (state_q)
            ST_START: begin
               if (tick) begin
                  state_q   <= mode_select_q ? ST_SINGLE : ST_CONV;
                  instr_q   <= 2'h0;
                  bit_idx_q <= 3'h7;
               end
            end
            ST_CONV: begin
               if (tick) begin
                  instr_q <= (instr_q == BIT_LAST) ? 2'h0 : instr_q + 2'h1;
               end
               if (bit_end) begin
                  bit_idx_q <= bit_idx_q - 3'h1;
                  if (bit_idx_q == 3'h0) begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            ST_SINGLE: begin
               if (!mode_select_q) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         conversion_start_q <= 1'b0;
      end else if (start_wr) begin
         conversion_start_q <= req.wdata[BIT_START];
      end else if (state_q == ST_START && tick) begin
         conversion_start_q <= 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         mode_select_q <= MODE_RST;
      end else if (flags_wr) begin
         mode_select_q <= req.wdata[BIT_MODE];
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N || start_wr) begin
         conversion_done_q <= 1'b0;
      end else if (done_evt) begin
         conversion_done_q <= 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N || start_set) begin
         conv_data_q <= DATA_RST;
      end else if (data_wr) begin
         conv_data_q <= req.wdata;
      end else if (bit_end) begin
         conv_data_q[bit_idx_q] <= COMP_IN;
      end
   end

   // settle count after start or write
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N || start_set || data_wr) begin
         settle_q <= 2'h0;
      end else if (tick && !settled && (state_q == ST_START || state_q == ST_SINGLE)) begin
         settle_q <= settle_q + 2'h1;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N || data_wr || start_set) begin
         compare_result_q <= 1'b0;
      end else if (state_q == ST_CONV) begin
         compare_result_q <= COMP_IN;
      end else if (state_q == ST_SINGLE && settled) begin
         compare_result_q <= COMP_IN;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         DAC_CODE <= DATA_RST;
      end else begin
         DAC_CODE <= trial_d;
      end
   end

   // ****************************************
   // Interrupts and read port
   // ****************************************
   // Set beats a same-cycle write-one clear so no event is lost
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         irq_stat_q <= IRQ_RST;
         irq_mask_q <= IRQ_RST;
         IRQ        <= 1'b0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~(stat_wr ? req.wdata[1:0] : 2'h0)) | {cmp_evt, done_evt};
         if (mask_wr) begin
            irq_mask_q <= req.wdata[1:0];
         end
         IRQ <= |(irq_stat_q & irq_mask_q);
      end
   end

   // Unmapped addresses and idle cycles read as zero
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N || !req.rd) begin
         BUS_RDATA <= 8'h00;
      end else if (req.addr == OFS_FLAGS) begin
         BUS_RDATA <= {5'h00, conversion_done_q, compare_result_q, mode_select_q};
      end else if (req.addr == OFS_START) begin
         BUS_RDATA <= {7'h00, conversion_start_q};
      end else if (req.addr == OFS_DATA) begin
         BUS_RDATA <= conv_data_q;
      end else if (req.addr == OFS_IRQ_STAT) begin
         BUS_RDATA <= {6'h00, irq_stat_q};
      end else if (req.addr == OFS_IRQ_MASK) begin
         BUS_RDATA <= {6'h00, irq_mask_q};
      end else begin
         BUS_RDATA <= 8'h00;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   logic [7:0] conv_len_q;
   always_ff @(posedge CORE_CLK) begin
      // A restart in mid-conversion measures from the new start write
      if (!RST_N || start_set || !(state_q == ST_START || state_q == ST_CONV)) begin
         conv_len_q <= 8'h00;
      end else begin
         conv_len_q <= conv_len_q + 8'h01;
      end
   end

   a_done_low_busy: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (state_q == ST_CONV) |-> !conversion_done_q) else $error("done high during conversion");
   a_done_start_clr: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      start_wr |=> !conversion_done_q) else $error("done not cleared by start write");
   a_single_cmp_follow: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (state_q == ST_SINGLE && settled && !data_wr && !start_set) |=> (compare_result_q == $past(COMP_IN)))
      else $error("single compare does not follow comparator");
   a_cmp_hold_settle: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (state_q == ST_SINGLE && !settled) |-> !compare_result_q) else $error("compare set before settle");
   a_conv_cmp_track: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (state_q == ST_CONV && !data_wr && !start_set) |=> (compare_result_q == $past(COMP_IN)))
      else $error("compare not tracking conversion");
   a_write_clr_cmp: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      data_wr |=> !compare_result_q) else $error("compare not cleared by data write");
   a_mode_route: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (state_q == ST_START && tick && !start_set) |=> (state_q == ($past(mode_select_q) ? ST_SINGLE : ST_CONV)))
      else $error("wrong mode entered");
   a_start_self_clr: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      start_set ##1 (!req.wr)[*4] |=> !conversion_start_q) else $error("start flag not self cleared");
   a_start_zero_data: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      start_set |=> (conv_data_q == 8'h00)) else $error("data not zeroed by start");
   a_conv_length: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      $rose(conversion_done_q) |-> (conv_len_q == CONV_LEN)) else $error("conversion length wrong");
   a_reset_flags: assert property (@(posedge CORE_CLK)
      !$past(RST_N) |-> (!mode_select_q && !compare_result_q)) else $error("flags not cleared by reset");

   c_conv_done: cover property (@(posedge CORE_CLK) disable iff (!RST_N) done_evt);
   c_single_high: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
      (state_q == ST_SINGLE) && settled && compare_result_q);
   c_restart: cover property (@(posedge CORE_CLK) disable iff (!RST_N) (state_q == ST_CONV) && start_set);
endmodule
`default_nettype wire

/* File: hdl/adc_flag_pkg.sv */
// Package: register map, field positions, timing and types of the converter flag block
package adc_flag_pkg;
   // ****************************************
   // Register bus
   // ****************************************
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam logic [ADDR_W-1:0] OFS_FLAGS    = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_START    = 8'h01;
   localparam logic [ADDR_W-1:0] OFS_DATA     = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h05;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h06;

   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int unsigned BIT_MODE  = 0;
   localparam int unsigned BIT_CMP   = 1;
   localparam int unsigned BIT_DONE  = 2;
   localparam int unsigned BIT_START = 0;
   localparam int unsigned IRQ_DONE  = 0;
   localparam int unsigned IRQ_CMP   = 1;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   localparam logic [1:0]        IRQ_RST  = 2'h0;
   localparam logic              MODE_RST = 1'b0;

   // ****************************************
   // Timing in instruction times, clock cycles and ns
   // ****************************************
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned INSTR_CYCLES  = 4;
   localparam int unsigned BIT_INSTR     = 3;
   localparam int unsigned CONV_INSTR    = 25;
   localparam int unsigned START_INSTR   = CONV_INSTR - 8 * BIT_INSTR;
   localparam int unsigned SETTLE_INSTR  = 2;
   localparam int unsigned CONV_CYCLES   = CONV_INSTR * INSTR_CYCLES;
   localparam logic [1:0]  TICK_LAST     = 2'(INSTR_CYCLES - 1);
   localparam logic [1:0]  BIT_LAST      = 2'(BIT_INSTR - 1);
   localparam logic [1:0]  SETTLE_DONE   = 2'(SETTLE_INSTR);
   localparam logic [7:0]  CONV_LEN      = 8'(CONV_CYCLES);

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0001,
      ST_START  = 4'b0010,
      ST_CONV   = 4'b0100,
      ST_SINGLE = 4'b1000
   } state_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } bus_req_type;
endpackage

/* File: bench/adc_flag_control_tb.sv */
// Self-checking testbench of the converter flag block
`timescale 1ns/100ps
`default_nettype none
module adc_flag_control_tb
   import adc_flag_pkg::*;
;
   logic              clk;
   logic              rst_n;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic              wr;
   logic              rd;
   logic [DATA_W-1:0] rdata;
   logic              comp;
   logic [DATA_W-1:0] dac;
   logic              irq;
   logic [8:0]        analog2;
   int                error_cnt;
   int                checked;

   adc_flag_control adc_flag_control_i (
      .CORE_CLK  (clk),
      .RST_N     (rst_n),
      .BUS_ADDR  (addr),
      .BUS_WDATA (wdata),
      .BUS_WR    (wr),
      .BUS_RD    (rd),
      .BUS_RDATA (rdata),
      .COMP_IN   (comp),
      .DAC_CODE  (dac),
      .IRQ       (irq)
   );

   // ****************************************
   // Clock and comparator
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Analog level kept at twice the code plus one, so it never equals a trial code
   always @(posedge clk) begin
      comp <= ({dac, 1'b0} < analog2);
   end

   // ****************************************
   // Bus tasks and comparison
   // ****************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   // Read data live only in the cycle after the strobe
   task automatic check_rd(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      check(rdata & mask, exp);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Bounded wait; running out of cycles ends the run
   task automatic wait_irq;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 200) begin
         @(posedge clk);
         #1;
         n++;
      end
      check({7'h00, irq}, 8'h01);
      if (irq !== 1'b1) begin
         conclude();
      end
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic reset_values;
      check_rd(OFS_FLAGS, 8'hFF, 8'h00);
      check_rd(OFS_DATA, 8'hFF, DATA_RST);
      check_rd(OFS_START, 8'hFF, 8'h00);
      check({7'h00, irq}, 8'h00);
   endtask

   task automatic successive_conv;
      analog2 <= 9'h0D9;
      wr_reg(OFS_IRQ_MASK, 8'h03);
      wr_reg(OFS_DATA, 8'hFF);
      wr_reg(OFS_START, 8'h01);
      repeat (7) @(posedge clk);
      check_rd(OFS_START, 8'hFF, 8'h00);
      check_rd(OFS_DATA, 8'hFF, 8'h00);
      check_rd(OFS_FLAGS, 8'h05, 8'h00);
      repeat (84) @(posedge clk);
      check_rd(OFS_FLAGS, 8'h04, 8'h00);
      check_rd(OFS_FLAGS, 8'h04, 8'h04);
      check({7'h00, irq}, 8'h01);
      check_rd(OFS_DATA, 8'hFF, 8'h6C);
      check_rd(OFS_IRQ_STAT, 8'h01, 8'h01);
   endtask

   task automatic irq_and_clear;
      wr_reg(OFS_IRQ_MASK, 8'h00);
      settle(2);
      check({7'h00, irq}, 8'h00);
      wr_reg(OFS_IRQ_MASK, 8'h01);
      settle(2);
      check({7'h00, irq}, 8'h01);
      wr_reg(OFS_IRQ_STAT, 8'h01);
      settle(2);
      check({7'h00, irq}, 8'h00);
      // Restart over a finished result, then clear the done flag with a zero start write
      wr_reg(OFS_START, 8'h01);
      check_rd(OFS_FLAGS, 8'h04, 8'h00);
      wait_irq();
      check_rd(OFS_FLAGS, 8'h04, 8'h04);
      wr_reg(OFS_START, 8'h00);
      check_rd(OFS_FLAGS, 8'h04, 8'h00);
      wr_reg(OFS_IRQ_STAT, 8'h03);
   endtask

   task automatic single_compare;
      wr_reg(OFS_FLAGS, 8'h01);
      wr_reg(OFS_START, 8'h01);
      settle(12);
      check_rd(OFS_FLAGS, 8'h05, 8'h01);
      wr_reg(OFS_IRQ_STAT, 8'h03);
      wr_reg(OFS_DATA, 8'h80);
      settle(1);
      check(dac, 8'h80);
      settle(10);
      check_rd(OFS_FLAGS, 8'h07, 8'h01);
      wr_reg(OFS_IRQ_STAT, 8'h03);
      wr_reg(OFS_DATA, 8'h40);
      settle(12);
      check_rd(OFS_FLAGS, 8'h07, 8'h03);
      check_rd(OFS_IRQ_STAT, 8'h02, 8'h02);
      // Same code again: result must drop until the compare settles anew
      wr_reg(OFS_DATA, 8'h40);
      check_rd(OFS_FLAGS, 8'h02, 8'h00);
      settle(12);
      check_rd(OFS_FLAGS, 8'h02, 8'h02);
   endtask

   task automatic reset_mid_run;
      // Unmask the pending compare event so reset has a live interrupt to drop
      wr_reg(OFS_IRQ_MASK, 8'h02);
      wr_reg(OFS_DATA, 8'h5A);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      check_rd(OFS_FLAGS, 8'hFF, 8'h00);
      check_rd(OFS_DATA, 8'hFF, 8'h00);
      check({7'h00, irq}, 8'h00);
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      error_cnt = 0;
      checked   = 0;
      rst_n     = 1'b0;
      addr      = 8'h00;
      wdata     = 8'h00;
      wr        = 1'b0;
      rd        = 1'b0;
      comp      = 1'b0;
      analog2   = 9'h000;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      reset_values();
      successive_conv();
      irq_and_clear();
      single_compare();
      reset_mid_run();
      conclude();
   end
endmodule
`default_nettype wire
